// >>> logic/acfg_if.sv
// carrier between the register bank and the rate generator
// assumes both ends share clk_i
`timescale 1ns/1ps
`default_nettype none

interface acfg_if;
  import acfg_pkg::*;
  acfg_rate_t rate_code;
  acfg_freq_t freq_code;
  logic       sample_tick;
  logic       test_wave;

  modport ctl (output rate_code, output freq_code,
               input sample_tick, input test_wave);
  modport gen (input rate_code, input freq_code,
               output sample_tick, output test_wave);
endinterface : acfg_if

`default_nettype wire

// >>> logic/acfg_params.svh
// named constants for the global configuration register bank
// assumes inclusion by bare name from the package and the modules
`ifndef ACFG_PARAMS_SVH
`define ACFG_PARAMS_SVH

// register indexes; byte address is four times the index
`define ACFG_IDX_RATE      6'h01
`define ACFG_IDX_TEST      6'h02
`define ACFG_IDX_BIAS      6'h03
`define ACFG_IDX_IRQ_STAT  6'h10
`define ACFG_IDX_IRQ_CLR   6'h11
`define ACFG_IDX_IRQ_EN    6'h12

// reset values
`define ACFG_RST_RATE      8'h96
`define ACFG_RST_TEST      8'hc0
`define ACFG_RST_BIAS      8'h60

// field positions, rate/clock/mode register
`define ACFG_B_READBACK    6
`define ACFG_B_CLK_EN      5
`define ACFG_F_RATE_HI     2
// field positions, test signal register
`define ACFG_B_TEST_INT    4
`define ACFG_B_TEST_AMP    2
`define ACFG_F_FREQ_HI     1
// field positions, reference/bias register
`define ACFG_B_REFBUF      7
`define ACFG_B_BIAS_ROUTE  4
`define ACFG_B_BIAS_REFINT 3
`define ACFG_B_BIAS_BUF    2
`define ACFG_B_BIAS_SENSE  1
`define ACFG_B_BIAS_STAT   0

// codes and timing
`define ACFG_MUX_BIAS      3'h2
`define ACFG_RATE_RSVD     3'h7
`define ACFG_FREQ_RSVD     2'h2
`define ACFG_RATE_LOG2     6
`define ACFG_TEST_LOG2     21
`define ACFG_IRQ_W         3
`define ACFG_EV_LEADOFF    0
`define ACFG_EV_SAMPLE     1
`define ACFG_EV_BADCODE    2

`endif

// >>> logic/acfg_pkg.sv
// types shared by the configuration bank and its rate generator
// assumes acfg_params.svh is on the include path
`default_nettype none
`include "acfg_params.svh"

package acfg_pkg;

  // test signal frequency codes
  typedef enum logic [1:0]
  {
    ACFG_FREQ_SLOW = 2'h0,
    ACFG_FREQ_FAST = 2'h1,
    ACFG_FREQ_RSVD = 2'h2,
    ACFG_FREQ_DC   = 2'h3
  } acfg_freq_t;

  typedef logic [2:0] acfg_rate_t;
  typedef logic [7:0] acfg_byte_t;

endpackage : acfg_pkg

`default_nettype wire

// >>> logic/acfg_rate_gen.sv
// modulator rate divider, output rate ticks and test waveform
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "acfg_params.svh"

module acfg_rate_gen
  import acfg_pkg::*;
#(
  parameter int unsigned RATE_LOG2 = `ACFG_RATE_LOG2,
  parameter int unsigned TEST_LOG2 = `ACFG_TEST_LOG2
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  acfg_if.gen       cfg
);

  localparam int unsigned CW = RATE_LOG2 + 7;

  logic          mod_en_r;
  logic [CW-1:0] rate_cnt_r;
  logic [CW-1:0] rate_lim;
  logic [TEST_LOG2-1:0] test_cnt_r;
  logic          tick_r;
  logic          wave_r;

  // -----------------------------------------------------------------
  // modulator enable and rate ticks
  // -----------------------------------------------------------------
  // last count of one output period, in modulator steps
  assign rate_lim = CW'((CW'(1) << (RATE_LOG2 + cfg.rate_code)) - 1);

  // modulator steps at half the clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mod_en_r <= 1'b0;
    else
      mod_en_r <= ~mod_en_r;
  end

  // reserved rate code yields no ticks at all, safer than guessing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r <= 1'b0;
      if (cfg.rate_code == `ACFG_RATE_RSVD)
        rate_cnt_r <= '0;
      else if (mod_en_r)
      begin
        if (rate_cnt_r >= rate_lim)
        begin
          rate_cnt_r <= '0;
          tick_r     <= 1'b1;
        end
        else
          rate_cnt_r <= CW'(rate_cnt_r + 1'b1);
      end
    end
  end

  // -----------------------------------------------------------------
  // test waveform
  // -----------------------------------------------------------------
  // free counter; top bit has period of 2^TEST_LOG2 clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      test_cnt_r <= '0;
      wave_r     <= 1'b0;
    end
    else
    begin
      test_cnt_r <= TEST_LOG2'(test_cnt_r + 1'b1);
      case (cfg.freq_code)
        ACFG_FREQ_SLOW: wave_r <= test_cnt_r[TEST_LOG2-1];
        ACFG_FREQ_FAST: wave_r <= test_cnt_r[TEST_LOG2-2];
        ACFG_FREQ_DC:   wave_r <= 1'b1;
        default:        wave_r <= 1'b0;
      endcase
    end
  end

  assign cfg.sample_tick = tick_r;
  assign cfg.test_wave   = wave_r;

endmodule : acfg_rate_gen

`default_nettype wire

// >>> logic/acfg_regs.sv
// global configuration register bank of a multichannel converter
// assumes a classic wishbone master, one clock, synchronous reset
//
// Contract
// - rate register at 0x01, resets 0x96
// - bit6 picks daisy-chain or multiple readback
// - bit5 drives oscillator out when pin high
// - rate divides half clock by 64..4096
// - test register at 0x02, resets 0xC0
// - bit4 picks internal or external test source
// - bit2 sets test amplitude one or two
// - bits1:0 set test pulse rate or dc
// - reference/bias register at 0x03, resets 0x60
// - bit7 powers reference buffer
// - bit4 routes bias to mux-010 channels
// - bit3 picks internal or external bias reference
// - bit2 powers bias buffer
// - bit1 enables bias sense
// - bit0 read-only lead-off status, reset 0
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acfg_params.svh"

module acfg_regs
  import acfg_pkg::*;
#(
  parameter int unsigned NCH       = 8,
  parameter int unsigned ADR_W     = 8,
  parameter int unsigned RATE_LOG2 = `ACFG_RATE_LOG2,
  parameter int unsigned TEST_LOG2 = `ACFG_TEST_LOG2
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // device pins and analog-side status
  input  wire logic             clock_source_pin_i,
  input  wire logic             bias_lead_off_i,
  input  wire logic [NCH*3-1:0] chan_mux_i,
  // configuration outputs
  output logic                  multi_readback_o,
  output logic                  osc_clk_out_en_o,
  output logic                  sample_tick_o,
  output logic                  test_internal_o,
  output logic                  test_amplitude_select_o,
  output logic                  test_wave_o,
  output logic                  refbuf_on_o,
  output logic      [NCH-1:0]   bias_sampling_route_o,
  output logic                  bias_ref_internal_o,
  output logic                  bias_buffer_on_o,
  output logic                  bias_sense_enable_o,
  output logic                  irq_o
);

  localparam int unsigned IW = ADR_W - 2;

  // -----------------------------------------------------------------
  // register map, byte addresses
  // -----------------------------------------------------------------
  // 0x04  rate, clock output and readout mode, read/write
  // 0x08  test signal source, amplitude and frequency, read/write
  // 0x0c  reference and bias controls, bit 0 read-only status
  // 0x40  interrupt status, read-only, sticky
  // 0x44  interrupt clear, write ones to clear, reads zero
  // 0x48  interrupt enable, same layout as the status word
  // event bits: 0 bias lead-off, 1 output sample, 2 forbidden code
  // every access is answered one cycle after it is seen, so the
  // master never waits longer; unmapped words read zero and drop
  // writes, which keeps a stray pointer harmless
  // only the low byte lane carries data; the upper lanes read zero

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  acfg_byte_t          rate_cfg_r;
  acfg_byte_t          test_cfg_r;
  acfg_byte_t          bias_cfg_r;
  logic                bias_stat_r;
  logic                ack_r;
  logic [31:0]         dat_r;
  logic [IW-1:0]       idx;
  logic                req;
  logic                wr_commit;
  logic                lane0;
  logic [`ACFG_IRQ_W-1:0] irq_stat_r;
  logic [`ACFG_IRQ_W-1:0] irq_en_r;
  logic [`ACFG_IRQ_W-1:0] irq_ev;
  logic [`ACFG_IRQ_W-1:0] irq_clr;
  logic                bad_code_wr;
  logic                osc_en_r;
  logic [NCH-1:0]      route_r;
  acfg_byte_t          rd_byte;

  acfg_if cfg_bus ();

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  // word index from the byte address; the two low bits are ignored
  assign idx   = wb_adr_i[ADR_W-1:2];
  assign req   = wb_cyc_i & wb_stb_i;
  assign lane0 = wb_sel_i[0];

  // writes land on the edge at which the master sees ack high
  assign wr_commit = req & wb_we_i & ack_r & lane0;

  // ack one cycle after the request, dropped the cycle after;
  // a master that holds its request longer sees ack toggle, so
  // it must release at the first ack as classic cycles require
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  assign wb_ack_o = ack_r;

  // -----------------------------------------------------------------
  // rate, clock and readout mode register
  // -----------------------------------------------------------------
  // all eight bits are stored as written; reserved fields rely on
  // software writing their fixed values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rate_cfg_r <= `ACFG_RST_RATE;
    else if (wr_commit && idx == `ACFG_IDX_RATE)
      rate_cfg_r <= wb_dat_i[7:0];
  end

  // -----------------------------------------------------------------
  // test signal register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      test_cfg_r <= `ACFG_RST_TEST;
    else if (wr_commit && idx == `ACFG_IDX_TEST)
      test_cfg_r <= wb_dat_i[7:0];
  end

  // -----------------------------------------------------------------
  // reference and bias register
  // -----------------------------------------------------------------
  // bit 0 is never written; its storage is the status flop below
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bias_cfg_r <= `ACFG_RST_BIAS;
    else if (wr_commit && idx == `ACFG_IDX_BIAS)
    begin
      bias_cfg_r[7:1] <= wb_dat_i[7:1];
      bias_cfg_r[0]   <= 1'b0;
    end
  end

  // lead-off status follows the sense comparator, not software;
  // one flop of delay, which also gives the edge detector its
  // previous value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bias_stat_r <= 1'b0;
    else
      bias_stat_r <= bias_lead_off_i;
  end

  // -----------------------------------------------------------------
  // interrupt enable register
  // -----------------------------------------------------------------
  // enables only mask the output; status keeps collecting events
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_en_r <= '0;
    else if (wr_commit && idx == `ACFG_IDX_IRQ_EN)
      irq_en_r <= wb_dat_i[`ACFG_IRQ_W-1:0];
  end

  // -----------------------------------------------------------------
  // events and sticky status
  // -----------------------------------------------------------------
  // a write that stores a forbidden rate or frequency code is flagged
  // so software learns of it; the value is still stored
  assign bad_code_wr = wr_commit &&
    ((idx == `ACFG_IDX_RATE &&
      wb_dat_i[`ACFG_F_RATE_HI:0] == `ACFG_RATE_RSVD) ||
     (idx == `ACFG_IDX_TEST &&
      wb_dat_i[`ACFG_F_FREQ_HI:0] == `ACFG_FREQ_RSVD));

  // lead-off raises on the disconnect edge only
  always_comb
  begin
    irq_ev = '0;
    irq_ev[`ACFG_EV_LEADOFF] = bias_lead_off_i & ~bias_stat_r;
    irq_ev[`ACFG_EV_SAMPLE]  = cfg_bus.sample_tick;
    irq_ev[`ACFG_EV_BADCODE] = bad_code_wr;
  end

  // write-one-to-clear strobe
  assign irq_clr = (wr_commit && idx == `ACFG_IDX_IRQ_CLR) ?
                   wb_dat_i[`ACFG_IRQ_W-1:0] : '0;

  // an event in the clearing cycle survives: set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------
  // unmapped words and the clear register read as zero; the
  // status bit is read live so software never sees a stale copy
  always_comb
  begin
    rd_byte = '0;
    case (idx)
      `ACFG_IDX_RATE: rd_byte = rate_cfg_r;
      `ACFG_IDX_TEST: rd_byte = test_cfg_r;
      `ACFG_IDX_BIAS: rd_byte = {bias_cfg_r[7:1], bias_stat_r};
      `ACFG_IDX_IRQ_STAT: rd_byte = acfg_byte_t'(irq_stat_r);
      `ACFG_IDX_IRQ_EN:   rd_byte = acfg_byte_t'(irq_en_r);
      default:        rd_byte = '0;
    endcase
  end

  // read data is captured with the ack and held until the next one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= '0;
    else if (req && !ack_r)
      dat_r <= {24'h00_0000, rd_byte};
  end

  assign wb_dat_o = dat_r;

  // -----------------------------------------------------------------
  // rate generator
  // -----------------------------------------------------------------
  assign cfg_bus.rate_code = rate_cfg_r[`ACFG_F_RATE_HI:0];
  assign cfg_bus.freq_code =
    acfg_freq_t'(test_cfg_r[`ACFG_F_FREQ_HI:0]);

  // the generator sees only the two codes and owns all counters,
  // so this bank stays a plain register file; a code change takes
  // effect at once, and the first period after it may be short
  acfg_rate_gen #(
    .RATE_LOG2 (RATE_LOG2),
    .TEST_LOG2 (TEST_LOG2)
  ) u_rate_gen (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cfg   (cfg_bus.gen)
  );

  assign sample_tick_o = cfg_bus.sample_tick;
  // test waveform stays low while the source is external
  assign test_wave_o   = cfg_bus.test_wave &
                         test_cfg_r[`ACFG_B_TEST_INT];

  // -----------------------------------------------------------------
  // clock output enable
  // -----------------------------------------------------------------
  // with the pin low the clock pin is an input, so never drive it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      osc_en_r <= 1'b0;
    else
      osc_en_r <= clock_source_pin_i &
                  rate_cfg_r[`ACFG_B_CLK_EN];
  end

  assign osc_clk_out_en_o = osc_en_r;

  // -----------------------------------------------------------------
  // bias measurement routing, one switch per channel
  // -----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_route
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          route_r[ch] <= 1'b0;
        else
          route_r[ch] <= bias_cfg_r[`ACFG_B_BIAS_ROUTE] &&
            (chan_mux_i[ch*3 +: 3] == `ACFG_MUX_BIAS);
      end
    end
  endgenerate

  assign bias_sampling_route_o = route_r;

  // -----------------------------------------------------------------
  // configuration fields to the analog side
  // -----------------------------------------------------------------
  // 0 selects daisy chain, 1 multiple readback
  assign multi_readback_o =
    rate_cfg_r[`ACFG_B_READBACK];
  assign test_internal_o =
    test_cfg_r[`ACFG_B_TEST_INT];
  // 0 gives one unit of ref span/2400, 1 gives two
  assign test_amplitude_select_o =
    test_cfg_r[`ACFG_B_TEST_AMP];
  assign refbuf_on_o =
    bias_cfg_r[`ACFG_B_REFBUF];
  assign bias_ref_internal_o =
    bias_cfg_r[`ACFG_B_BIAS_REFINT];
  assign bias_buffer_on_o =
    bias_cfg_r[`ACFG_B_BIAS_BUF];
  assign bias_sense_enable_o =
    bias_cfg_r[`ACFG_B_BIAS_SENSE];

endmodule : acfg_regs

`default_nettype wire

// >>> tb/acfg_regs_props.sv
// concurrent checks on the configuration bank's ports
// assumes bind onto acfg_regs, one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module acfg_regs_props #(
  parameter int unsigned NCH   = 8,
  parameter int unsigned ADR_W = 8
)(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             clock_source_pin_i,
  input wire logic [NCH*3-1:0] chan_mux_i,
  input wire logic             multi_readback_o,
  input wire logic             osc_clk_out_en_o,
  input wire logic             sample_tick_o,
  input wire logic             test_internal_o,
  input wire logic             test_amplitude_select_o,
  input wire logic             test_wave_o,
  input wire logic             refbuf_on_o,
  input wire logic [NCH-1:0]   bias_sampling_route_o,
  input wire logic             bias_ref_internal_o,
  input wire logic             bias_buffer_on_o,
  input wire logic             bias_sense_enable_o
);
  // ----------------------------------------
  // helper: index committed at the last edge
  // ----------------------------------------
  // 3f marks no commit, so a stray change can never match a register
  logic [5:0] wr_idx_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !(wb_ack_o && wb_we_i && wb_sel_i[0]))
      wr_idx_r <= 6'h3f;
    else
      wr_idx_r <= wb_adr_i[7:2];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_timing: assert property (s_req |=> s_ack_pulse)
    else $error("ack missing or longer than one cycle");
  a_read_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");

  // ----------------------------------------
  // outputs change only through their own register
  // ----------------------------------------
  a_mode_by_write: assert property (
    $changed(multi_readback_o) |-> wr_idx_r == 6'h01)
    else $error("readout mode changed without a write");
  a_test_by_write: assert property (
    $changed({test_internal_o, test_amplitude_select_o})
      |-> wr_idx_r == 6'h02)
    else $error("test settings changed without a write");
  a_bias_by_write: assert property (
    $changed({refbuf_on_o, bias_ref_internal_o, bias_buffer_on_o,
              bias_sense_enable_o}) |-> wr_idx_r == 6'h03)
    else $error("reference or bias setting changed without a write");

  // ----------------------------------------
  // gating of derived outputs
  // ----------------------------------------
  a_osc_pin_gate: assert property (
    !$past(clock_source_pin_i) |-> !osc_clk_out_en_o)
    else $error("oscillator driven out while pin low");
  a_route_mux: assert property (
    chan_mux_i[2:0] != 3'h2 |=> !bias_sampling_route_o[0])
    else $error("bias routed to a channel not set to 010");
  a_wave_gate: assert property (
    !test_internal_o |-> !test_wave_o)
    else $error("internal test wave while external source chosen");
  a_tick_pulse: assert property (
    sample_tick_o |=> !sample_tick_o)
    else $error("sample tick longer than one cycle");
endmodule : acfg_regs_props

bind acfg_regs acfg_regs_props #(.NCH(NCH), .ADR_W(ADR_W)) u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_o, .wb_ack_o, .clock_source_pin_i, .chan_mux_i,
  .multi_readback_o, .osc_clk_out_en_o, .sample_tick_o, .test_internal_o,
  .test_amplitude_select_o, .test_wave_o, .refbuf_on_o,
  .bias_sampling_route_o, .bias_ref_internal_o, .bias_buffer_on_o,
  .bias_sense_enable_o);

`default_nettype wire

// >>> tb/acfg_regs_tb.sv
// self-checking bench for the configuration register bank
// assumes short counts: rate log2 of 1 and test log2 of 4
`timescale 1ns/1ps
`default_nettype none

module acfg_regs_tb;
  localparam int RL = 1;
  localparam int TL = 4;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        wb_ack_o, clock_source_pin_i, bias_lead_off_i;
  logic [23:0] chan_mux_i;
  logic        multi_readback_o, osc_clk_out_en_o, sample_tick_o;
  logic        test_internal_o, test_amplitude_select_o, test_wave_o;
  logic        refbuf_on_o, bias_ref_internal_o, bias_buffer_on_o;
  logic        bias_sense_enable_o, irq_o;
  logic [7:0]  bias_sampling_route_o, outs;
  int          failures, n_checks, n;
  // rows: address, write data, read back, output levels
  // reserved fields hold their fixed values
  logic [31:0] rows [7] = '{32'h04f6_f6c0, 32'h08d7_d7f0, 32'h0cff_fef0 |
    32'h0000_000f, 32'h0c60_60f0, 32'h0496_9630, 32'h08c0_c000,
    32'h20ff_0000};
  logic [7:0]  rv [3] = '{8'h96, 8'hc0, 8'h60};

  assign outs = {multi_readback_o, osc_clk_out_en_o, test_internal_o,
    test_amplitude_select_o, refbuf_on_o, bias_ref_internal_o,
    bias_buffer_on_o, bias_sense_enable_o};

  acfg_regs #(.RATE_LOG2(RL), .TEST_LOG2(TL)) DUT (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .clock_source_pin_i, .bias_lead_off_i,
    .chan_mux_i, .multi_readback_o, .osc_clk_out_en_o, .sample_tick_o,
    .test_internal_o, .test_amplitude_select_o, .test_wave_o,
    .refbuf_on_o, .bias_sampling_route_o, .bias_ref_internal_o,
    .bias_buffer_on_o, .bias_sense_enable_o, .irq_o);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // classic cycle; ack and read data are taken at one rising edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [7:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    if (k >= 50)
      failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  // let edges land, then look in the quiet half of the cycle
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  // cycles between two rising edges of the wave or the tick; 0 if none
  task automatic period(input logic w, output int p);
    logic pv, cv;
    int   e;
    pv = 1'b1;
    e  = 0;
    p  = 0;
    for (int k = 0; k < 600 && e < 2; k++)
    begin
      settle(0);
      cv = w ? test_wave_o : sample_tick_o;
      if (e == 1)
        p++;
      if (cv && !pv)
        e++;
      pv = cv;
    end
    if (e < 2)
      p = 0;
  endtask : period

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (30000) @(posedge clk_i);
    failures++;
    conclude();
  end

  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, bias_lead_off_i} = 4'h0;
    {rst_i, clock_source_pin_i} = 2'h3;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    chan_mux_i = 24'h44_924a; // channels 0 and 7 select 010
    failures = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      bus(rows[i][31:24], 1'b1, rows[i][23:16], q);
      bus(rows[i][31:24], 1'b0, 8'h00, q);
      chk(q, 32'(rows[i][15:8]));
      settle(2);
      chk(32'(outs), 32'(rows[i][7:0]));
    end
    // second reset mid-run brings back the documented values
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      bus(8'(4 * (i + 1)), 1'b0, 8'h00, q);
      chk(q, 32'(rv[i]));
    end
    settle(0);
    chk(32'({outs, irq_o}), 32'h0000_0000);
    // every rate code: period is two clocks per modulator clock, no ticks for reserved code 7
    for (int c = 0; c < 8; c++)
    begin
      bus(8'h04, 1'b1, 8'h90 | 8'(c), q);
      period(1'b0, n);
      period(1'b0, n);
      chk(32'(n), c == 7 ? 32'h0000_0000 : 32'(2 * (2 ** (RL + c))));
    end
    // oscillator output only while the pin is high
    bus(8'h04, 1'b1, 8'hb6, q);
    @(posedge clk_i);
    clock_source_pin_i <= 1'b0;
    settle(2);
    chk(32'(osc_clk_out_en_o), 32'h0000_0000);
    @(posedge clk_i);
    clock_source_pin_i <= 1'b1;
    settle(2);
    chk(32'(osc_clk_out_en_o), 32'h0000_0001);
    // test wave: slow, fast, forbidden code
    for (int c = 0; c < 3; c++)
    begin
      bus(8'h08, 1'b1, 8'hd0 | 8'(c), q);
      period(1'b1, n);
      period(1'b1, n);
      chk(32'(n), c == 2 ? 32'h0000_0000 : 32'((2 ** TL) >> c));
    end
    chk(32'(test_wave_o), 32'h0000_0000);
    // bias route only to channels that select 010
    bus(8'h0c, 1'b1, 8'h70, q);
    settle(2);
    chk(32'(bias_sampling_route_o), 32'h0000_0081);
    @(posedge clk_i);
    chan_mux_i <= 24'h44_9249; // channel 0 now selects 001
    settle(2);
    chk(32'(bias_sampling_route_o), 32'h0000_0080);
    @(posedge clk_i);
    chan_mux_i <= 24'h44_924a;
    bus(8'h0c, 1'b1, 8'h60, q);
    settle(2);
    chk(32'(bias_sampling_route_o), 32'h0000_0000);
    // lead-off: status sticks, masked until enabled, then cleared
    @(posedge clk_i);
    bias_lead_off_i <= 1'b1;
    settle(4);
    chk(32'(irq_o), 32'h0000_0000);
    bus(8'h48, 1'b1, 8'h01, q);
    settle(1);
    chk(32'(irq_o), 32'h0000_0001);
    bus(8'h0c, 1'b1, 8'h60, q);
    bus(8'h0c, 1'b0, 8'h00, q);
    chk(q, 32'h0000_0061);
    bus(8'h44, 1'b1, 8'h01, q);
    settle(1);
    chk(32'(irq_o), 32'h0000_0000);
    @(posedge clk_i);
    bias_lead_off_i <= 1'b0;
    settle(2);
    bus(8'h0c, 1'b0, 8'h00, q);
    chk(q, 32'h0000_0060);
    // sample ticks and forbidden codes stay sticky, lead-off cleared
    bus(8'h40, 1'b0, 8'h00, q);
    chk(q, 32'h0000_0006);
    conclude();
  end
endmodule : acfg_regs_tb

`default_nettype wire
